// File: design/dsrc_top.sv
// dsrc_top: special registers between sequence program and drive
// assumes wishbone master and drive core on clk_i; terminals are pins
// Behaviour
// - full-clear codes clear every parameter
// - partial-clear codes keep communication parameters
// - good clear: completion with error zero
// - bad code or running: error all-ones
// - run word bits 0..11 drive inputs
// - bits mapped by function params, no sequence-start
// - network mode: bit0 forward, bit1 reverse
// - mask bits enable word and flag bits
// - masked functions ignore terminal and remote
// - sequence-start always from terminal or remote only
// - word and mask ignored in panel mode
// - failed parameter write stores number plus 8000h
// - other failures store all-ones; reset zero
// - error code held until zero written
// - status word follows drive state continuously
// - alarm value 16..20 raises fault, stops
// - alarm disabled while enable param zero
// - selection 40..42 shows monitor 1..3
// - two-bit field picks display resolution
// - other decimal-point bits are ignored
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module dsrc_top
  import dsrc_pkg::*;
#(
  parameter int NBITS = 12
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // drive core
  input  wire logic [1:0]        mode_i,
  input  wire logic              motor_running_i,
  input  wire logic [15:0]       drive_state_i,
  input  wire logic              param_write_fail_i,
  input  wire logic [14:0]       param_num_i,
  input  wire logic              other_fail_i,
  input  wire logic              fault_reset_i,
  // parameters held by the drive
  input  wire logic [NBITS-1:0][FN_W-1:0] input_function_params_i,
  input  wire logic [15:0]       user_alarm_enable_param_i,
  input  wire logic [2:0][7:0]   monitor_selection_params_i,
  // input sources
  input  wire logic [NBITS-1:0]  ext_term_i,
  input  wire logic [NBITS-1:0]  net_remote_i,
  // results
  output logic [(1<<FN_W)-1:0]   func_active_o,
  output logic                   clear_all_o,
  output logic                   clear_keep_comm_o,
  output logic                   user_fault_o,
  output logic [4:0]             user_fault_code_o,
  output logic                   drive_stop_o,
  output dsrc_disp_s [2:0]       disp_o
);

  // the control word is sixteen bits wide at most
  if (NBITS < 2 || NBITS > 16) begin : g_bad
    $error("dsrc_top: NBITS must lie in 2..16");
  end

  // full or partial clear code test
  function automatic logic code_full(input logic [15:0] c);
    code_full = (c == CLR_ALL_A) || (c == CLR_ALL_B);
  endfunction : code_full

  function automatic logic code_keep(input logic [15:0] c);
    code_keep = (c == CLR_KEEP_A) || (c == CLR_KEEP_B);
  endfunction : code_keep

  // byte-lane merge of the low half-word
  function automatic logic [15:0] merge16(input logic [15:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge16

  logic [15:0]      clr_code_r;
  logic [15:0]      run_r;
  logic [15:0]      mask_r;
  logic [15:0]      err_r;
  logic [15:0]      status_r;
  logic [15:0]      alarm_r;
  logic [15:0]      dp_r;
  logic [2:0][15:0] mon_r;
  logic [1:0]       ctrl_r;
  logic [15:0]      flags_r;
  logic             cmd_prev_r;
  dsrc_clr_e        clr_st_r;
  logic [NBITS-1:0] term_s1_r;
  logic [NBITS-1:0] term_s2_r;
  logic [NBITS-1:0] term_s3_r;
  logic [NBITS-1:0] term_q_r;

  // bus decode
  logic        req;
  logic        wr;
  logic [15:0] rd_nxt;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr  = req && wb_we_i && wb_ack_o;

  function automatic logic wr_at(input logic [7:0] a, input logic w, input logic [7:0] ad);
    wr_at = w && (ad == a);
  endfunction : wr_at

  // ack one cycle after the request; write lands on the acked edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= {16'h0000, rd_nxt};
    end
  end

  // read mux; unmapped addresses and write-only code read zero
  always_comb begin
    rd_nxt = 16'h0000;
    unique case (wb_adr_i)
      OFS_RUN_WORD:  rd_nxt = run_r;
      OFS_RUN_MASK:  rd_nxt = mask_r;
      OFS_ERR_CODE:  rd_nxt = err_r;
      OFS_STATUS:    rd_nxt = status_r;
      OFS_ALARM:     rd_nxt = alarm_r;
      OFS_DP:        rd_nxt = dp_r;
      OFS_MON1:      rd_nxt = mon_r[0];
      OFS_MON2:      rd_nxt = mon_r[1];
      OFS_MON3:      rd_nxt = mon_r[2];
      OFS_CTRL:      rd_nxt = {14'h0000, ctrl_r};
      OFS_CLR_STAT:  rd_nxt = {15'h0000, clr_st_r == CLR_DONE};
      OFS_RUN_FLAGS: rd_nxt = flags_r;
      default:       rd_nxt = 16'h0000;
    endcase
  end

  // plain storage registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_code_r <= RST_WORD;
      run_r      <= RST_WORD;
      mask_r     <= RST_WORD;
      flags_r    <= RST_WORD;
      dp_r       <= RST_WORD;
      mon_r      <= '0;
      ctrl_r     <= 2'b00;
    end else if (ce_i) begin
      if (wr_at(OFS_CLR_CODE, wr, wb_adr_i))  clr_code_r <= merge16(clr_code_r, wb_dat_i, wb_sel_i);
      // word and mask stay accessible in every mode
      if (wr_at(OFS_RUN_WORD, wr, wb_adr_i))  run_r <= merge16(run_r, wb_dat_i, wb_sel_i);
      if (wr_at(OFS_RUN_MASK, wr, wb_adr_i))  mask_r <= merge16(mask_r, wb_dat_i, wb_sel_i);
      if (wr_at(OFS_RUN_FLAGS, wr, wb_adr_i)) flags_r <= merge16(flags_r, wb_dat_i, wb_sel_i);
      if (wr_at(OFS_DP, wr, wb_adr_i))        dp_r <= merge16(dp_r, wb_dat_i, wb_sel_i);
      if (wr_at(OFS_MON1, wr, wb_adr_i))      mon_r[0] <= merge16(mon_r[0], wb_dat_i, wb_sel_i);
      if (wr_at(OFS_MON2, wr, wb_adr_i))      mon_r[1] <= merge16(mon_r[1], wb_dat_i, wb_sel_i);
      if (wr_at(OFS_MON3, wr, wb_adr_i))      mon_r[2] <= merge16(mon_r[2], wb_dat_i, wb_sel_i);
      if (wr_at(OFS_CTRL, wr, wb_adr_i) && wb_sel_i[0]) ctrl_r <= wb_dat_i[1:0];
    end
  end

  // status word copied every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) status_r <= RST_WORD;
    else if (ce_i) status_r <= drive_state_i;
  end

  // parameter clear: act only on the command's rising edge
  logic clr_fire;
  logic clr_ok_full;
  logic clr_ok_keep;
  assign clr_fire    = ctrl_r[CTRL_CLR_CMD_BIT] && !cmd_prev_r;
  assign clr_ok_full = !motor_running_i && code_full(clr_code_r);
  assign clr_ok_keep = !motor_running_i && code_keep(clr_code_r);

  // completion stays on until the command is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_prev_r        <= 1'b0;
      clr_st_r          <= CLR_IDLE;
      clear_all_o       <= 1'b0;
      clear_keep_comm_o <= 1'b0;
    end else if (ce_i) begin
      cmd_prev_r        <= ctrl_r[CTRL_CLR_CMD_BIT];
      clear_all_o       <= clr_fire && clr_ok_full;
      clear_keep_comm_o <= clr_fire && clr_ok_keep;
      unique case (clr_st_r)
        CLR_IDLE: if (clr_fire) clr_st_r <= CLR_DONE;
        CLR_DONE: if (!ctrl_r[CTRL_CLR_CMD_BIT]) clr_st_r <= CLR_IDLE;
      endcase
    end
  end

  // error code: the clear command outranks hardware events, which outrank the zero write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= ERR_NONE;
    end else if (ce_i) begin
      if (clr_fire) begin
        err_r <= (clr_ok_full || clr_ok_keep) ? ERR_NONE : ERR_ALL1;
      end else if (param_write_fail_i) begin
        err_r <= ERR_PARAM | {1'b0, param_num_i};
      end else if (other_fail_i) begin
        err_r <= ERR_ALL1;
      end else if (wr_at(OFS_ERR_CODE, wr, wb_adr_i) && merge16(err_r, wb_dat_i, wb_sel_i) == ERR_NONE) begin
        err_r <= ERR_NONE;
      end
    end
  end

  // user alarm; out-of-range values are stored but do nothing
  logic alarm_fire;
  assign alarm_fire = wr_at(OFS_ALARM, wr, wb_adr_i)
                   && user_alarm_enable_param_i != 16'h0000
                   && merge16(alarm_r, wb_dat_i, wb_sel_i) >= ALARM_LO
                   && merge16(alarm_r, wb_dat_i, wb_sel_i) <= ALARM_HI;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r           <= RST_WORD;
      user_fault_o      <= 1'b0;
      user_fault_code_o <= 5'h00;
      drive_stop_o      <= 1'b0;
    end else if (ce_i) begin
      if (wr_at(OFS_ALARM, wr, wb_adr_i)) alarm_r <= merge16(alarm_r, wb_dat_i, wb_sel_i);
      user_fault_o <= alarm_fire;
      if (alarm_fire) begin
        user_fault_code_o <= wb_dat_i[4:0];
        drive_stop_o      <= 1'b1;
      end else if (fault_reset_i) begin
        drive_stop_o <= 1'b0;
      end
    end
  end

  // terminal pins: three stages, accept a level when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_s1_r <= '0;
      term_s2_r <= '0;
      term_s3_r <= '0;
      term_q_r  <= '0;
    end else if (ce_i) begin
      term_s1_r <= ext_term_i;
      term_s2_r <= term_s1_r;
      term_s3_r <= term_s2_r;
      for (int i = 0; i < NBITS; i++) begin
        if (term_s2_r[i] == term_s3_r[i]) term_q_r[i] <= term_s3_r[i];
      end
    end
  end

  // function vector built from terminals, remote inputs and program bits
  logic [(1<<FN_W)-1:0] func_nxt;
  logic [(1<<FN_W)-1:0] term_vec;
  always_comb begin
    logic             prog_on;
    logic [FN_W-1:0]  pfn;
    logic [FN_W-1:0]  tfn;
    logic             owned;
    func_nxt = '0;
    term_vec = '0;
    prog_on  = 1'b0;
    pfn      = '0;
    tfn      = '0;
    owned    = 1'b0;
    for (int i = 0; i < NBITS; i++) begin
      tfn = input_function_params_i[i];
      pfn = input_function_params_i[i];
      if (dsrc_mode_e'(mode_i) == MODE_NET && i == 0) pfn = FN_FWD;
      if (dsrc_mode_e'(mode_i) == MODE_NET && i == 1) pfn = FN_REV;
      // mask ownership only outside panel mode
      owned   = mask_r[i] && dsrc_mode_e'(mode_i) != MODE_PANEL;
      // run word used only once the select flag is set
      prog_on = owned && (pfn != FN_SEQ)
             && ((ctrl_r[CTRL_SEL_BIT] && run_r[i]) || flags_r[i]);
      if (prog_on) func_nxt[pfn] = 1'b1;
      // sequence-start never taken from the program bits
      if ((!owned || tfn == FN_SEQ) && (term_q_r[i] || net_remote_i[i])) begin
        func_nxt[tfn] = 1'b1;
      end
      if (term_q_r[i] || net_remote_i[i]) term_vec[tfn] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) func_active_o <= '0;
    else if (ce_i) func_active_o <= func_nxt;
  end

  // panel display slots, one per monitor selection parameter
  for (genvar k = 0; k < 3; k++) begin : g_disp
    logic [7:0] sel;
    logic [1:0] idx;
    assign sel = monitor_selection_params_i[k] - MON_SEL_BASE;
    assign idx = sel[1:0];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        disp_o[k] <= '0;
      end else if (ce_i) begin
        disp_o[k].valid <= sel < 8'd3;
        disp_o[k].value <= (sel < 8'd3) ? mon_r[idx] : 16'h0000;
        // only the three two-bit fields are looked at
        disp_o[k].dp    <= (sel < 8'd3) ? dp_r[DP_LSB + 2*idx +: 2] : 2'b00;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_clear_full_ok: assert property (clear_all_o |-> clr_st_r == CLR_DONE && err_r == ERR_NONE)
    else $error("full clear without good completion");
  chk_clear_keep_ok: assert property (clear_keep_comm_o |-> !clear_all_o && err_r == ERR_NONE)
    else $error("partial clear without good completion");
  chk_clear_bad_code: assert property (ce_i && clr_fire && !clr_ok_full && !clr_ok_keep
      |=> err_r == ERR_ALL1 && clr_st_r == CLR_DONE && !clear_all_o && !clear_keep_comm_o)
    else $error("bad clear did not flag error");
  chk_reset_zero: assert property ($past(rst_i) |-> run_r == 16'h0000 && mask_r == 16'h0000
      && err_r == 16'h0000)
    else $error("control registers not zero after reset");
  chk_net_forward: assert property (ce_i && mode_i == MODE_NET && mask_r[0] && ctrl_r[CTRL_SEL_BIT]
      && run_r[0] |=> func_active_o[FN_FWD])
    else $error("net mode bit0 did not give forward start");
  chk_panel_terms: assert property (ce_i && mode_i == MODE_PANEL |=> func_active_o == $past(term_vec))
    else $error("panel mode used program bits");
  chk_seq_terminal: assert property (ce_i |=> func_active_o[FN_SEQ] == $past(term_vec[FN_SEQ]))
    else $error("sequence start raised from program");
  chk_param_fail: assert property (ce_i && !clr_fire && param_write_fail_i
      |=> err_r == (ERR_PARAM | {1'b0, $past(param_num_i)}))
    else $error("parameter error code wrong");
  chk_err_hold: assert property (err_r != ERR_NONE && !(ce_i && (clr_fire || param_write_fail_i
      || other_fail_i || wr)) |=> $stable(err_r))
    else $error("error code changed on its own");
  chk_alarm_stop: assert property (ce_i && alarm_fire |=> user_fault_o && drive_stop_o)
    else $error("user alarm did not stop drive");
  chk_alarm_off: assert property (user_fault_o |-> $past(user_alarm_enable_param_i) != 16'h0000)
    else $error("user alarm fired while disabled");
  chk_mon_show: assert property (ce_i && monitor_selection_params_i[0] == 8'd41
      |=> disp_o[0].valid && disp_o[0].value == $past(mon_r[1]) && disp_o[0].dp == $past(dp_r[11:10]))
    else $error("monitor 2 not shown");
  chk_dp_field: assert property (ce_i && monitor_selection_params_i[1] == 8'd42
      |=> disp_o[1].dp == $past(dp_r[13:12]))
    else $error("decimal point field wrong");

  cov_clear_good: cover property (clear_all_o);
  cov_clear_bad: cover property (ce_i && clr_fire && !clr_ok_full && !clr_ok_keep);
  cov_alarm: cover property (user_fault_o);
  cov_prog_fwd: cover property (func_active_o[FN_FWD] && mask_r[0]);

endmodule : dsrc_top

// File: inc/dsrc_pkg.sv
// dsrc_pkg: constants and types of the drive special-register block
// assumes one 100 MHz clock and a 32-bit classic wishbone register bus
package dsrc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CLR_CODE  = 8'h00;
  localparam logic [7:0] OFS_RUN_WORD  = 8'h04;
  localparam logic [7:0] OFS_RUN_MASK  = 8'h08;
  localparam logic [7:0] OFS_ERR_CODE  = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_ALARM     = 8'h14;
  localparam logic [7:0] OFS_DP        = 8'h18;
  localparam logic [7:0] OFS_MON1      = 8'h1c;
  localparam logic [7:0] OFS_MON2      = 8'h20;
  localparam logic [7:0] OFS_MON3      = 8'h24;
  localparam logic [7:0] OFS_CTRL      = 8'h28;
  localparam logic [7:0] OFS_CLR_STAT  = 8'h2c;
  localparam logic [7:0] OFS_RUN_FLAGS = 8'h30;
  // control register fields
  localparam int CTRL_CLR_CMD_BIT = 0;
  localparam int CTRL_SEL_BIT     = 1;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  // clear codes
  localparam logic [15:0] CLR_ALL_A  = 16'h9696;
  localparam logic [15:0] CLR_ALL_B  = 16'h9966;
  localparam logic [15:0] CLR_KEEP_A = 16'h5a5a;
  localparam logic [15:0] CLR_KEEP_B = 16'h55aa;
  // error codes
  localparam logic [15:0] ERR_NONE   = 16'h0000;
  localparam logic [15:0] ERR_ALL1   = 16'hffff;
  localparam logic [15:0] ERR_PARAM  = 16'h8000;
  // user alarm range
  localparam logic [15:0] ALARM_LO = 16'h0010;
  localparam logic [15:0] ALARM_HI = 16'h0014;
  // input function numbers
  localparam int FN_W = 6;
  localparam logic [FN_W-1:0] FN_SEQ = 6'h32;
  localparam logic [FN_W-1:0] FN_FWD = 6'h3c;
  localparam logic [FN_W-1:0] FN_REV = 6'h3d;
  // monitor selection codes and decimal-point fields
  localparam logic [7:0] MON_SEL_BASE = 8'h28;
  localparam int DP_LSB = 8;
  // operating modes
  typedef enum logic [1:0] {
    MODE_NET   = 2'b00,
    MODE_EXT   = 2'b01,
    MODE_PANEL = 2'b10
  } dsrc_mode_e;
  // clear handshake state
  typedef enum logic {
    CLR_IDLE = 1'b0,
    CLR_DONE = 1'b1
  } dsrc_clr_e;
  // one panel display slot
  typedef struct packed {
    logic        valid;
    logic [1:0]  dp;
    logic [15:0] value;
  } dsrc_disp_s;
endpackage : dsrc_pkg

// File: tb/dsrc_drive_model.sv
// dsrc_drive_model: behavioural drive core on the far side of the block
// assumes the block's clk_i and its synchronous active-high reset
`timescale 1ns/1ps
module dsrc_drive_model
  import dsrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // commands from the block
  input  wire logic [63:0] func_active_i,
  input  wire logic        drive_stop_i,
  // state and failure reports back
  output logic             motor_running_o,
  output logic [15:0]      drive_state_o,
  output logic             param_write_fail_o = 1'b0,
  output logic [14:0]      param_num_o = 15'h7fff,
  output logic             other_fail_o = 1'b0
);
  logic [11:0] tick_r;
  // a start command runs the motor unless a user fault stopped it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motor_running_o <= 1'b0;
      tick_r          <= 12'h000;
    end else begin
      motor_running_o <= (func_active_i[FN_FWD] | func_active_i[FN_REV]) & ~drive_stop_i;
      tick_r          <= tick_r + 12'h001;
    end
  end
  // low bits move every cycle so a frozen status copy shows up
  assign drive_state_o = {motor_running_o, drive_stop_i, 2'b00, tick_r};
  // one-cycle failure report; number inverted afterwards, not held
  task automatic report_fail(input logic prm, input logic [14:0] num);
    param_write_fail_o <= prm;
    other_fail_o       <= ~prm;
    param_num_o        <= num;
    @(posedge clk_i);
    param_write_fail_o <= 1'b0;
    other_fail_o       <= 1'b0;
    param_num_o        <= ~num;
  endtask : report_fail
endmodule : dsrc_drive_model

// File: tb/testbench.sv
// testbench: random and corner tests of the special-register block
// assumes dsrc_top with the wishbone map and timing of its package
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  import dsrc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, fault_rst = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h3, lanes = 4'h3;
  logic [31:0] dat = 32'h0, dat_o, rd;
  logic [1:0]  mode = 2'b01;
  logic [11:0] term = 12'h000, remote = 12'h000, w, k;
  logic [11:0][5:0] fparams;
  logic [15:0] alarm_en = 16'h0000, state, code, dp;
  logic [2:0][7:0]  monsel = '0;
  logic [2:0][15:0] mv;
  logic [63:0] func;
  logic clr_all, clr_keep, ufault, stop, motor, pwf, ofail, fire;
  logic [4:0]  ucode;
  logic [14:0] pnum;
  logic [1:0]  e;
  logic [7:0]  n_all = 8'h00, n_keep = 8'h00, n_flt = 8'h00, na, nk, nf;
  dsrc_disp_s [2:0] disp;
  int checked = 0, mismatches = 0, cycles = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  dsrc_top uut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .mode_i(mode),
    .motor_running_i(motor), .drive_state_i(state), .param_write_fail_i(pwf), .param_num_i(pnum),
    .other_fail_i(ofail), .fault_reset_i(fault_rst), .input_function_params_i(fparams),
    .user_alarm_enable_param_i(alarm_en), .monitor_selection_params_i(monsel), .ext_term_i(term),
    .net_remote_i(remote), .func_active_o(func), .clear_all_o(clr_all), .clear_keep_comm_o(clr_keep),
    .user_fault_o(ufault), .user_fault_code_o(ucode), .drive_stop_o(stop), .disp_o(disp));
  dsrc_drive_model drv (.clk_i(clk), .rst_i(rst), .func_active_i(func), .drive_stop_i(stop),
    .motor_running_o(motor), .drive_state_o(state), .param_write_fail_o(pwf), .param_num_o(pnum),
    .other_fail_o(ofail));
  // tallies of one-cycle pulses, checked as differences
  always @(posedge clk) begin
    n_all  <= n_all + {7'h0, clr_all};
    n_keep <= n_keep + {7'h0, clr_keep};
    n_flt  <= n_flt + {7'h0, ufault};
  end
  // hang guard, far above the expected run of a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= wr;
    adr <= a;
    dat <= d;
    sel <= lanes;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      $display("BAD %0t no bus answer", $time);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // active functions from mode, word, mask and terminals
  function automatic logic [63:0] exp_func(logic [1:0] m, logic [11:0] wd, logic [11:0] mk, logic [11:0] t);
    logic [63:0] v;
    v = '0;
    // net mode pins only the program's bits 0 and 1; terminals keep their own functions
    for (int b = 0; b < 12; b++) begin
      if (m != MODE_PANEL && mk[b] && b != 3) begin
        if (m == MODE_NET && b < 2) v[b ? FN_REV : FN_FWD] |= wd[b];
        else v[fparams[b]] |= wd[b];
      end else v[fparams[b]] |= t[b];
    end
    return v;
  endfunction : exp_func
  // {full clear, partial clear}; none while running or on a bad code
  function automatic logic [1:0] exp_clr(logic [15:0] c, logic r);
    if (r) return 2'b00;
    return {c == CLR_ALL_A || c == CLR_ALL_B, c == CLR_KEEP_A || c == CLR_KEEP_B};
  endfunction : exp_clr
  // panel slot contents for a selection code of 40 to 42
  function automatic dsrc_disp_s exp_disp(logic [7:0] s, logic [15:0] d, logic [2:0][15:0] m);
    int i;
    i = int'(s) - 40;
    return {1'b1, d[8 + 2 * i +: 2], m[i]};
  endfunction : exp_disp
  // main sequence
  initial begin
    for (int b = 0; b < 12; b++) fparams[b] <= (b == 3) ? FN_SEQ : 6'(b + 1);
    void'($urandom(32'h3478));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 5; a++) begin
      wb(1'b0, (a == 4) ? 8'hfc : 8'(4 * a), 32'h0, rd);
      `CHK(rd, 32'h0)
    end
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK(rd[31:14], 18'h0)
    wb(1'b1, OFS_CTRL, 32'h2, rd);
    for (int i = 0; i < 12; i++) begin
      mode <= 2'(i % 3);
      term <= 12'($urandom);
      w = (i < 3) ? 12'hfff : 12'($urandom);
      k = (i < 3) ? 12'hfff : 12'($urandom);
      wb(1'b1, OFS_RUN_WORD, {20'h0, w}, rd);
      wb(1'b1, OFS_RUN_MASK, {20'h0, k}, rd);
      repeat (6) @(posedge clk);
      `CHK(func, exp_func(mode, w, k, term))
      wb(1'b0, OFS_RUN_MASK, 32'h0, rd);
      `CHK(rd, {20'h0, k})
    end
    mode <= MODE_NET;
    term <= 12'h000;
    remote <= 12'hff7;
    wb(1'b1, OFS_RUN_WORD, 32'h0, rd);
    wb(1'b1, OFS_RUN_MASK, 32'hfff, rd);
    wb(1'b1, OFS_RUN_FLAGS, 32'h10, rd);
    repeat (6) @(posedge clk);
    `CHK(func, 64'h20)
    wb(1'b1, OFS_RUN_FLAGS, 32'h0, rd);
    remote <= 12'h000;
    for (int i = 0; i < 7; i++) begin
      code = (i < 4) ? ((i < 2) ? (i ? CLR_ALL_B : CLR_ALL_A) : (i == 2 ? CLR_KEEP_A : CLR_KEEP_B))
                     : ((i == 6) ? CLR_KEEP_A : 16'($urandom));
      wb(1'b1, OFS_RUN_WORD, (i == 6) ? 32'h1 : 32'h0, rd);
      repeat (4) @(posedge clk);
      `CHK(motor, i == 6)
      drv.report_fail(1'b1, 15'($urandom));
      e = exp_clr(code, i == 6);
      na = n_all;
      nk = n_keep;
      wb(1'b1, OFS_CLR_CODE, {16'h0, code}, rd);
      wb(1'b1, OFS_CTRL, 32'h3, rd);
      wb(1'b0, OFS_CLR_STAT, 32'h0, rd);
      `CHK(rd[0], 1'b1)
      wb(1'b0, OFS_ERR_CODE, 32'h0, rd);
      `CHK(rd[15:0], (e == 2'b00) ? ERR_ALL1 : ERR_NONE)
      wb(1'b1, OFS_CTRL, 32'h3, rd);
      `CHK(n_all - na, {7'h0, e[1]})
      `CHK(n_keep - nk, {7'h0, e[0]})
      wb(1'b1, OFS_CTRL, 32'h2, rd);
      wb(1'b0, OFS_CLR_STAT, 32'h0, rd);
      `CHK(rd[0], 1'b0)
    end
    pnum_chk: begin
      logic [14:0] p;
      p = 15'($urandom);
      drv.report_fail(1'b1, p);
      wb(1'b1, OFS_ERR_CODE, 32'h1234, rd);
      wb(1'b0, OFS_ERR_CODE, 32'h0, rd);
      `CHK(rd[15:0], ERR_PARAM + {1'b0, p})
      wb(1'b1, OFS_ERR_CODE, 32'h0, rd);
      wb(1'b0, OFS_ERR_CODE, 32'h0, rd);
      `CHK(rd[15:0], ERR_NONE)
      drv.report_fail(1'b0, p);
      wb(1'b0, OFS_ERR_CODE, 32'h0, rd);
      `CHK(rd[15:0], ERR_ALL1)
    end
    for (int v = 15; v < 23; v++) begin
      alarm_en <= (v == 22) ? 16'h0000 : 16'h0100;
      code = (v == 22) ? 16'd17 : 16'(v);
      fire = (v != 22) && code >= ALARM_LO && code <= ALARM_HI;
      nf = n_flt;
      wb(1'b1, OFS_ALARM, {16'h0, code}, rd);
      repeat (2) @(posedge clk);
      `CHK(n_flt - nf, {7'h0, fire})
      `CHK(stop, fire)
      if (fire) `CHK(ucode, code[4:0])
      wb(1'b0, OFS_STATUS, 32'h0, rd);
      `CHK(rd[14], fire)
      fault_rst <= 1'b1;
      @(posedge clk);
      fault_rst <= 1'b0;
    end
    monsel <= {8'd40, 8'd42, 8'd41};
    for (int i = 0; i < 3; i++) begin
      mv[i] = 16'($urandom);
      wb(1'b1, 8'(OFS_MON1 + 4 * i), {16'h0, mv[i]}, rd);
    end
    dp = 16'($urandom);
    wb(1'b1, OFS_DP, {16'h0, dp}, rd);
    repeat (2) @(posedge clk);
    for (int s = 0; s < 3; s++) `CHK(disp[s], exp_disp(monsel[s], dp, mv))
    monsel[0] <= 8'd39;
    repeat (2) @(posedge clk);
    `CHK(disp[0].valid, 1'b0)
    // high lane only: the low byte of monitor 1 must survive
    lanes = 4'h2;
    wb(1'b1, OFS_MON1, 32'h0, rd);
    lanes = 4'h3;
    wb(1'b0, OFS_MON1, 32'h0, rd);
    `CHK(rd[15:0], {8'h00, mv[0][7:0]})
    // second reset in mid-run: word, mask and error code back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 1; a < 4; a++) begin
      wb(1'b0, 8'(4 * a), 32'h0, rd);
      `CHK(rd, 32'h0)
    end
    end_sim();
  end
endmodule : testbench
